// *** rtl/adse_consts.vh ***
// Purpose: Constants for the scan-completion signalling block
// Assumes: 250 MHz peripheral clock
// Notes: Times in ns; the guard count is 1 us at the 4 ns clock, sized to the counter
`ifndef ADSE_CONSTS_VH
`define ADSE_CONSTS_VH
`define ADSE_MODE_SINGLE 2'h0
`define ADSE_MODE_GROUP 2'h1
`define ADSE_MODE_CONT 2'h2
`define ADSE_MODE_BAD 2'h3
`define ADSE_CLK_PERIOD_NS 4
`define ADSE_MSTP_WAIT_NS 1000
`define ADSE_MSTP_WAIT_CYC 8'hfa
`define ADSE_CNT_W 8
`define ADSE_CNT_ZERO 8'h00
`define ADSE_CNT_ONE 8'h01
`endif

// *** rtl/adse_scan_events.v ***
// Purpose: Scan-end interrupt and event-link signalling of a 12-bit converter
// Assumes: Scan-done strobes are one-cycle pulses from the converter sequencer
// Notes: Starts are refused while stopped, during the wake guard or for mode 11
`timescale 1ns/1ps
`default_nettype none
`include "adse_consts.vh"
module adse_scan_events (
   input wire i_clk, // Peripheral clock
   input wire i_nrst, // Async reset, active low
   input wire [1:0] i_scan_mode, // Scan mode code
   input wire i_dbl_mode, // Double trigger mode select
   input wire i_irq_en, // Scan-end request enable
   input wire i_gb_irq_en, // Group B scan-end request enable
   input wire i_module_stop, // Module-stop state request
   input wire i_sw_start, // Software start pulse
   input wire i_sync_start, // Timer start pulse
   input wire i_elc_start, // Start pulse from event_link_controller
   input wire i_scan_done, // Scan completion pulse
   input wire i_scan_is_gb, // Completed scan was group B
   input wire i_cmp_event, // Window compare condition met
   output reg o_scan_start_q, // Start pulse to sequencer
   output wire o_ready, // Conversion may be started
   output reg o_scan_end_irq_q, // scan_end_irq, also dma/dtc activation
   output reg o_group_b_scan_end_irq_q, // group_b_scan_end_irq
   output reg o_elc_scan_end_q, // Link event, non group B scans
   output reg o_elc_gb_end_q, // Link event, group B scans
   output reg o_elc_all_end_q, // Link event, every scan
   output reg o_elc_cmp_q // Link event, window compare
);
   // Wake guard: cycles left before a start may be taken
   reg [`ADSE_CNT_W-1:0] wait_cnt_q;
   reg [`ADSE_CNT_W-1:0] wait_cnt_d;
   // Double trigger pairing: high once the first scan of a pair is done
   reg dbl_half_q;
   reg dbl_half_d;
   // Next values of the registered pulse outputs
   reg scan_start_d;
   reg scan_end_irq_d;
   reg group_b_scan_end_irq_d;
   reg elc_scan_end_d;
   reg elc_gb_end_d;
   reg elc_all_end_d;
   reg elc_cmp_d;
   // Decoded conditions
   wire mode_ok;
   wire is_single;
   wire is_group;
   wire gb_done;
   wire other_done;
   wire any_start;
   wire guard_done;
   wire irq_slot;

   // Mode decode; code 11 blocks starts, continuous needs no special case here
   assign mode_ok = (i_scan_mode != `ADSE_MODE_BAD);
   assign is_single = (i_scan_mode == `ADSE_MODE_SINGLE);
   assign is_group = (i_scan_mode == `ADSE_MODE_GROUP);

   // Completion split: a group B scan only exists in group scan mode
   assign gb_done = i_scan_done & is_group & i_scan_is_gb;
   assign other_done = i_scan_done & ~gb_done;

   // Outside double mode every non group B completion may raise the request; in double
   // mode only the second scan of a pair does
   assign irq_slot = ~i_dbl_mode | dbl_half_q;

   // Start sources: software, timer and the event linker
   assign any_start = i_sw_start | i_sync_start | i_elc_start;

   // Ready once out of module-stop, the wake guard has run down and the mode code is not 11
   assign guard_done = (wait_cnt_q == `ADSE_CNT_ZERO);
   assign o_ready = ~i_module_stop & guard_done & mode_ok;

   // Wake guard: reloaded while stopped, then counts down once per cycle
   always @*
   begin
      wait_cnt_d = wait_cnt_q;
      if (i_module_stop)
      begin
         wait_cnt_d = `ADSE_MSTP_WAIT_CYC;
      end
      else if (!guard_done)
      begin
         wait_cnt_d = wait_cnt_q - `ADSE_CNT_ONE;
      end
   end

   // Pairing: group B scans do not count, leaving double mode clears it
   always @*
   begin
      dbl_half_d = dbl_half_q;
      if (!i_dbl_mode)
      begin
         dbl_half_d = 1'b0;
      end
      else if (other_done)
      begin
         dbl_half_d = ~dbl_half_q;
      end
   end

   // Start request: any source, dropped unless the converter is ready
   always @*
   begin
      scan_start_d = 1'b0;
      if (any_start && o_ready)
      begin
         scan_start_d = 1'b1;
      end
   end

   // Scan-end request; the one pulse activates the CPU, DMA and transfer controller
   always @*
   begin
      scan_end_irq_d = 1'b0;
      if (i_irq_en && other_done && irq_slot)
      begin
         scan_end_irq_d = 1'b1;
      end
   end

   // Dedicated group B request, kept off the ordinary line
   always @*
   begin
      group_b_scan_end_irq_d = 1'b0;
      if (i_gb_irq_en && gb_done)
      begin
         group_b_scan_end_irq_d = 1'b1;
      end
   end

   // Link event for every completion that is not a group B scan
   always @*
   begin
      elc_scan_end_d = 1'b0;
      if (other_done)
      begin
         elc_scan_end_d = 1'b1;
      end
   end

   // Link event for group B completions only
   always @*
   begin
      elc_gb_end_d = 1'b0;
      if (gb_done)
      begin
         elc_gb_end_d = 1'b1;
      end
   end

   // Link event for every completion, whatever the group or mode
   always @*
   begin
      elc_all_end_d = 1'b0;
      if (i_scan_done)
      begin
         elc_all_end_d = 1'b1;
      end
   end

   // Window compare link event, only honoured in single scan mode
   always @*
   begin
      elc_cmp_d = 1'b0;
      if (i_cmp_event && is_single)
      begin
         elc_cmp_d = 1'b1;
      end
   end

   // Wake guard register; reset acts like a fresh release from module-stop
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wait_cnt_q <= `ADSE_MSTP_WAIT_CYC;
      end
      else
      begin
         wait_cnt_q <= wait_cnt_d;
      end
   end

   // Pairing register
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         dbl_half_q <= 1'b0;
      end
      else
      begin
         dbl_half_q <= dbl_half_d;
      end
   end

   // Start pulse to the sequencer
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_scan_start_q <= 1'b0;
      end
      else
      begin
         o_scan_start_q <= scan_start_d;
      end
   end

   // Scan-end request pulse
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_scan_end_irq_q <= 1'b0;
      end
      else
      begin
         o_scan_end_irq_q <= scan_end_irq_d;
      end
   end

   // Group B request pulse
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_group_b_scan_end_irq_q <= 1'b0;
      end
      else
      begin
         o_group_b_scan_end_irq_q <= group_b_scan_end_irq_d;
      end
   end

   // Non group B link event pulse
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_elc_scan_end_q <= 1'b0;
      end
      else
      begin
         o_elc_scan_end_q <= elc_scan_end_d;
      end
   end

   // Group B link event pulse
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_elc_gb_end_q <= 1'b0;
      end
      else
      begin
         o_elc_gb_end_q <= elc_gb_end_d;
      end
   end

   // All-scan link event pulse
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_elc_all_end_q <= 1'b0;
      end
      else
      begin
         o_elc_all_end_q <= elc_all_end_d;
      end
   end

   // Window compare link event pulse
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_elc_cmp_q <= 1'b0;
      end
      else
      begin
         o_elc_cmp_q <= elc_cmp_d;
      end
   end
endmodule
`default_nettype wire

// *** sim/adse_checker.sv ***
// Purpose: pulse checks Assumes: one clock Notes: bound to the block
`timescale 1ns/1ps
`default_nettype none
module adse_chk(input wire logic i_clk,i_nrst,i_module_stop,i_scan_done,i_scan_is_gb,o_ready,
   i_cmp_event,o_scan_end_irq_q,o_group_b_scan_end_irq_q,o_elc_scan_end_q,o_elc_gb_end_q,
   o_elc_all_end_q,o_elc_cmp_q,input wire logic [1:0] i_scan_mode);
   wire d=i_scan_done,g=d&&i_scan_is_gb&&i_scan_mode==1,n=d&&!g;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   property p_e; n|=>o_elc_scan_end_q; endproperty a_e: assert property(p_e) else $error("e");
   property p_b; g|=>o_elc_gb_end_q&&!o_elc_scan_end_q; endproperty a_b: assert property(p_b) else $error("b");
   property p_a; d|=>o_elc_all_end_q; endproperty a_a: assert property(p_a) else $error("a");
   property p_c; i_cmp_event&&i_scan_mode==0|=>o_elc_cmp_q; endproperty a_c: assert property(p_c) else $error("c");
   property p_m; $fell(i_module_stop)|=>!o_ready[*8]; endproperty a_m: assert property(p_m) else $error("m");
   property p_i; o_scan_end_irq_q|->$past(n); endproperty a_i: assert property(p_i) else $error("i");
   property p_g; o_group_b_scan_end_irq_q|->$past(g); endproperty a_g: assert property(p_g) else $error("g");
   property p_o; o_elc_all_end_q|->$past(d); endproperty a_o: assert property(p_o) else $error("o");
   // Cycles since reset or module-stop ended, saturating past the guard
   int gap;
   always @(posedge i_clk or negedge i_nrst)
      if(!i_nrst)
         gap<=0;
      else if(i_module_stop)
         gap<=0;
      else if(gap<300)
         gap<=gap+1;
   property p_w; o_ready|->gap>=250; endproperty a_w: assert property(p_w) else $error("w");
   property p_x; i_scan_mode==3|->!o_ready; endproperty a_x: assert property(p_x) else $error("x");
endmodule
bind adse_scan_events adse_chk adse_chk_i(.*);
`default_nettype wire

// *** sim/adse_elc.sv ***
// Purpose: event linker start Assumes: one clock Notes: passes requests
`timescale 1ns/1ps
`default_nettype none
module adse_elc(input wire logic i_go,output logic o_start);
   assign o_start=i_go;
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Purpose: random bench Assumes: 4 ns clock Notes: expected pulses queued
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin checks++; if((s)!==(e)) begin bad_count++; $display("Error %s %h %h",n,e,s); end end
module tb;
   logic i_clk=0,i_nrst=0,p=0,a,x,g,l;
   logic [11:0] v=0,r;
   logic [6:0] e,w,q[$];
   int bad_count=0,checks=0,i;
   wire [6:0] o;
   adse_elc adse_elc_i(.i_go(v[8]),.o_start(l));
   adse_scan_events adse_scan_events_i(.i_clk,.i_nrst,.i_scan_mode(v[1:0]),.i_dbl_mode(v[2]),
      .i_irq_en(v[3]),.i_gb_irq_en(v[4]),.i_module_stop(v[5]),.i_sw_start(v[6]),.i_sync_start(v[7]),
      .i_elc_start(l),.i_scan_done(v[9]),.i_scan_is_gb(v[10]),.i_cmp_event(v[11]),.o_ready(),
      .o_scan_start_q(o[6]),.o_scan_end_irq_q(o[5]),.o_group_b_scan_end_irq_q(o[4]),
      .o_elc_scan_end_q(o[3]),.o_elc_gb_end_q(o[2]),.o_elc_all_end_q(o[1]),.o_elc_cmp_q(o[0]));
   task test_done;
      `CHK("left",0,q.size())
      $display("checks %0d errors %0d",checks,bad_count);
      if(bad_count==0&&checks>0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial forever #2 i_clk=~i_clk;
   initial begin #9000; bad_count++; test_done; end
   // Each pulse group is matched against the oldest note
   always @(negedge i_clk) if(|o!==1'b0) begin w=q.size()?q.pop_front():7'h0; `CHK("out",w,o) end
   // Random traffic; starts kept clear of the guard edges
   initial begin
      void'($urandom(32'haed2));
      repeat(2) @(posedge i_clk);
      i_nrst<=1;
      for(i=0;i<1200;i++) begin
         @(posedge i_clk);
         r=12'($urandom);
         a=i<240||(i>=260&&i<560)||i>=580;
         g=r[9]&&r[10]&&r[1:0]==1;
         x=r[9]&&!g;
         e={((i>=260&&i<300)||i>=580)&&r[1:0]!=3&&|r[8:6],x&&r[3]&&(!i[7]||p),g&&r[4],x,g,r[9],
            r[11]&&r[1:0]==0};
         p=i[7]&&(p^x);
         if(|e) q.push_back(e);
         v<={r[11:9],r[8:6]&{3{a}},i>=300&&i<320,r[4:3],i[7],r[1:0]};
      end
      @(posedge i_clk);
      v<=12'h000;
      repeat(3) @(posedge i_clk);
      test_done;
   end
endmodule
`default_nettype wire
